// ===== bench/spi_irq_dma_ctrl_properties.sv
// Port-level checker for the SPI event block, bound to the top module
`timescale 1ns/10ps
module spi_irq_dma_ctrl_properties (
    input wire logic clk_in, // Core clock
    input wire logic rst_n_in, // Async reset
    input wire logic [15:0] ctrl_in, // Control word
    input wire logic [2:0] dma_ctrl_in, // DMA control
    input wire logic tx_byte_load_in, // Byte to shifter
    input wire logic transfer_start_in, // Transfer start
    input wire logic tx_fifo_empty_in, // Tx FIFO empty
    input wire logic tx_fifo_full_in, // Tx FIFO full
    input wire logic status_rd_in, // Status read
    input wire logic chip_select_n_in, // Chip select
    input wire logic mosi_out, // Master out value
    input wire logic miso_out, // Master in value
    input wire spi_irq_pkg::status_t status_out, // Status word
    input wire logic irq_out, // Interrupt line
    input wire spi_irq_pkg::dma_req_t dma_req_out // DMA requests
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_tx_load;
        tx_byte_load_in && ctrl_in[0] && ctrl_in[6] && !ctrl_in[13]
            && ctrl_in[15:14] == 2'h0 && !dma_ctrl_in[0];
    endsequence
    sequence s_cs_fall;
        $fell(chip_select_n_in) && status_out.rx_level == 3'h0;
    endsequence
    property p_tx_lat;
        s_tx_load |-> ##[3:5] status_out.tx_threshold_irq;
    endproperty
    a_tx_lat: assert property (p_tx_lat) else $error("tx irq late");
    property p_underrun;
        transfer_start_in && tx_fifo_empty_in && ctrl_in[0] && !ctrl_in[13]
            |-> ##[1:5] status_out.tx_underrun;
    endproperty
    a_underrun: assert property (p_underrun) else $error("no underrun");
    property p_irq_or;
        irq_out == (|{status_out[7:4], status_out.chip_select_error})
            && status_out.irq == irq_out;
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq mismatch");
    property p_tx_hold;
        $fell(status_out.tx_threshold_irq) || $fell(status_out.tx_underrun)
            |-> $past(status_rd_in) || !$past(ctrl_in[0]) || $past(ctrl_in[13]);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx flag lost");
    property p_rx_hold;
        $fell(status_out.rx_threshold_irq) || $fell(status_out.rx_overflow)
            |-> $past(status_rd_in) || !$past(ctrl_in[0]) || $past(ctrl_in[12]);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx flag lost");
    property p_tx_sel;
        $rose(status_out.tx_threshold_irq) |-> $past(ctrl_in[6], 2) && !$past(dma_ctrl_in[0], 2);
    endproperty
    a_tx_sel: assert property (p_tx_sel) else $error("tx irq unselected");
    property p_dma_off;
        !dma_ctrl_in[0] |-> dma_req_out == 2'b00;
    endproperty
    a_dma_off: assert property (p_dma_off) else $error("request while off");
    property p_dma_tx;
        dma_ctrl_in[0] && dma_ctrl_in[1] |-> dma_req_out.tx == !tx_fifo_full_in;
    endproperty
    a_dma_tx: assert property (p_dma_tx) else $error("tx request wrong");
    property p_od;
        ctrl_in[4] |-> !mosi_out && !miso_out;
    endproperty
    a_od: assert property (p_od) else $error("open drain drives high");
    property p_first_hold;
        s_cs_fall |=> (status_out.rx_level == 3'h0) [*8];
    endproperty
    a_first_hold: assert property (p_first_hold) else $error("level too early");
endmodule : spi_irq_dma_ctrl_properties
bind spi_irq_dma_ctrl spi_irq_dma_ctrl_properties i_props (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ctrl_in(ctrl_in), .dma_ctrl_in(dma_ctrl_in),
    .tx_byte_load_in(tx_byte_load_in), .transfer_start_in(transfer_start_in),
    .tx_fifo_empty_in(tx_fifo_empty_in), .tx_fifo_full_in(tx_fifo_full_in),
    .status_rd_in(status_rd_in), .chip_select_n_in(chip_select_n_in),
    .mosi_out(mosi_out), .miso_out(miso_out), .status_out(status_out),
    .irq_out(irq_out), .dma_req_out(dma_req_out));

// ===== bench/spi_link_partner.sv
// External SPI master model on the link side of the block
`timescale 1ns/10ps
module spi_link_partner (
    output logic link_clk_out, // Serial clock
    output logic cs_n_out, // Chip select
    output logic mosi_out // Data to block
);
    // ------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------
    initial begin
        link_clk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b1;
    end
    // Clock stands still outside frames; fewer than 8 bits aborts mid-byte
    task automatic send(input logic [7:0] data, input int nbits);
        int i;
        cs_n_out = 1'b0;
        #20;
        for (i = 7; i > 7 - nbits; i--) begin
            mosi_out = data[i];
            #7.5 link_clk_out = 1'b1;
            #7.5 link_clk_out = 1'b0;
        end
        #20;
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
    endtask : send
endmodule : spi_link_partner

// ===== bench/test_spi_irq_dma_ctrl.sv
// Self-checking bench for the SPI event block
`timescale 1ns/10ps
module test_spi_irq_dma_ctrl;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [15:0] ctrl = 16'h0000;
    logic [2:0] dma = 3'h0;
    logic [4:0] pul = 5'h00; // Write, start, load, pop, read
    logic tx_empty = 1'b0;
    logic tx_full = 1'b0;
    logic tx_bit = 1'b0;
    logic master = 1'b0;
    logic link_clk, cs_n, p_mosi, mosi_in, mosi_out, mosi_oe_n, miso_in, miso_out, miso_oe_n;
    logic [7:0] rx_data;
    spi_irq_pkg::status_t status;
    spi_irq_pkg::dma_req_t dma_req;
    logic irq;
    logic irq_seen = 1'b0;
    logic [15:0] exp_q[$];
    logic [7:0] bytes[4];
    logic [15:0] rx_exp[5] = '{16'h0100, 16'h0241, 16'h0341, 16'h0441, 16'h0481};
    int bad_count = 0;
    int samples_checked = 0;
    int seed = 59;
    int cycles = 0;
    int m, i;
    // ------------------------------------------------------------
    // Pins, clock and block
    // ------------------------------------------------------------
    assign mosi_in = mosi_oe_n ? p_mosi : mosi_out;
    assign miso_in = miso_oe_n ? 1'b1 : miso_out; // Pull-up when released
    always #2 clk_in = ~clk_in;
    spi_irq_dma_ctrl i_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk), .ctrl_in(ctrl),
        .ctrl_wr_in(pul[4]), .dma_ctrl_in(dma), .bit_counter_reset_in(1'b1),
        .master_mode_in(master), .status_rd_in(pul[0]), .rx_read_in(pul[1]),
        .tx_byte_load_in(pul[2]), .transfer_start_in(pul[3]), .tx_fifo_empty_in(tx_empty),
        .tx_fifo_full_in(tx_full), .tx_bit_in(tx_bit), .chip_select_n_in(cs_n),
        .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe_n_out(mosi_oe_n),
        .miso_in(miso_in), .miso_out(miso_out), .miso_oe_n_out(miso_oe_n),
        .rx_data_out(rx_data), .status_out(status), .irq_out(irq), .dma_req_out(dma_req));
    spi_link_partner i_partner (.link_clk_out(link_clk), .cs_n_out(cs_n), .mosi_out(p_mosi));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cyc
    task automatic pulse(input logic [4:0] p);
        pul = p;
        cyc(1);
        pul = 5'h00;
        cyc(1);
    endtask : pulse
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    // Each rising interrupt takes the oldest expected status word
    // Sampled on the falling edge, where the outputs have settled
    always @(negedge clk_in) begin
        irq_seen <= irq;
        cycles++;
        if (irq === 1'b1 && irq_seen !== 1'b1) begin
            if (exp_q.size() == 0) check(status, 16'hffff);
            else check(status, exp_q.pop_front());
        end
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        cyc(10);
        rst_n_in = 1'b1;
        for (m = 0; m < 4; m++) begin
            ctrl = {m[1:0], 14'h0041};
            pulse(5'h10);
            repeat (m) pulse(5'h04);
            pulse(5'h10);
            repeat (m) begin
                pulse(5'h04);
                cyc({$random(seed)} % 3);
            end
            cyc(5);
            check(irq, 1'b0);
            exp_q.push_back(16'h0021);
            pulse(5'h04);
            cyc(6);
            pulse(5'h01);
            check(irq, 1'b0);
        end
        $display("tx threshold done");
        ctrl = 16'h2041;
        tx_empty = 1'b1;
        pulse(5'h10);
        pulse(5'h04);
        pulse(5'h08);
        cyc(6);
        check(irq, 1'b0);
        ctrl = 16'h0001;
        pulse(5'h10);
        exp_q.push_back(16'h0011);
        pulse(5'h08);
        cyc(6);
        ctrl = 16'h4001;
        pulse(5'h10);
        check(status.tx_underrun, 1'b1);
        ctrl = 16'h0000;
        cyc(2);
        check(status, 16'h0000);
        tx_empty = 1'b0;
        $display("underrun done");
        ctrl = 16'h4001;
        pulse(5'h10);
        for (i = 0; i < 5; i++) begin
            if (i < 4) bytes[i] = $random(seed);
            if (i > 0) exp_q.push_back(rx_exp[i]);
            i_partner.send(bytes[i % 4], 8);
            cyc(20);
            check(status.rx_level, rx_exp[i][10:8]);
            if (i < 4) pulse(5'h01);
            check(irq, i == 4);
        end
        for (i = 0; i < 4; i++) begin
            check(rx_data, bytes[i]);
            pulse(5'h02);
        end
        check(status.rx_level, 3'h0);
        ctrl = 16'h5001;
        cyc(2);
        check(status, 16'h0000);
        i_partner.send(8'ha5, 8);
        cyc(20);
        check(status, 16'h0000);
        $display("receive done");
        exp_q.push_back(16'h1001);
        i_partner.send(8'h5a, 5);
        cyc(10);
        ctrl = 16'h0000;
        cyc(2);
        check(status, 16'h0000);
        $display("chip select error done");
        ctrl = 16'h0001;
        pulse(5'h10);
        dma = 3'h3;
        cyc(1);
        check(dma_req, 2'b10);
        tx_full = 1'b1;
        cyc(1);
        check(dma_req, 2'b00);
        dma = 3'h5;
        i_partner.send(8'h3c, 8);
        cyc(20);
        check(irq, 1'b0);
        check(dma_req.rx, 1'b1);
        check(rx_data, 8'h3c);
        exp_q.push_back(16'h0111);
        tx_empty = 1'b1;
        pulse(5'h08);
        cyc(6);
        dma = 3'h0;
        cyc(1);
        check(dma_req, 2'b00);
        $display("dma done");
        // Clear flags and pop the DMA byte, then run a master frame with open drain
        pulse(5'h03);
        ctrl = 16'h0011;
        master = 1'b1;
        tx_bit = 1'($random(seed));
        exp_q.push_back(16'h0141);
        i_partner.send(8'h00, 8);
        cyc(2);
        check({mosi_out, miso_out}, 2'b00);
        check(mosi_oe_n, tx_bit);
        check(miso_oe_n, 1'b1);
        check(rx_data, 8'hff);
        check(16'(exp_q.size()), 16'h0000);
        $display("open drain done");
        complete_run();
    end
endmodule : test_spi_irq_dma_ctrl

// ===== hdl/spi_irq_cfg.svh
// Field positions, reset values, FIFO depth and timing counts of the SPI event block
// Functional notes
// - Master full duplex: transmit or underrun interrupt 3 to 4 clocks after first byte.
// - Receive fill level ignores first byte until 12 clocks after chip select falls.
// - One interrupt line; status bit 0 mirrors it, bits 7:4 and 12 mirror the sources.
// - Control bit 6 selects transmit interrupt when set, receive interrupt when clear.
// - Transmit interrupt after every 1, 2, 3 or 4 bytes moved into the shifter.
// - Transmit interrupt is status bit 5, cleared on status read, blocked by control bit 13.
// - Any control write restarts the transmitted byte counter from zero.
// - Receive interrupt checked on each FIFO write against the mode threshold.
// - Receive interrupt is status bit 6, cleared on status read, blocked by control bit 12.
// - Transfer start with empty transmit FIFO sets underrun bit 4 and interrupts.
// - Byte arriving into full receive FIFO sets overflow bit 7 and interrupts.
// - Flags clear on status read or disable; flush bits clear their own flags.
// - Open-drain control bit 4 makes data outputs pull low only.
// - Chip select rising mid-byte sets status bit 12 and interrupts.
// - Separate transmit (bit 1) and receive (bit 2) DMA request enables.
// - Under DMA no threshold interrupts; underrun and overflow still interrupt.
// - DMA requests only while DMA enable bit 0 is one.
// - Transmit DMA request whenever the transmit FIFO has free space.
// - Receive FIFO holds four bytes; fill level codes 000 to 100.
`ifndef SPI_IRQ_CFG_SVH
`define SPI_IRQ_CFG_SVH
`define CTRL_ENABLE_BIT 0
`define CTRL_OPEN_DRAIN_BIT 4
`define CTRL_IRQ_SRC_SEL_BIT 6
`define CTRL_RX_FLUSH_BIT 12
`define CTRL_TX_FLUSH_BIT 13
`define CTRL_MODE_HI 15
`define CTRL_MODE_LO 14
`define DMA_ENABLE_BIT 0
`define DMA_TX_BIT 1
`define DMA_RX_BIT 2
`define STATUS_RESET 16'h0000
`define RX_FIFO_DEPTH 4
`define TX_IRQ_LAT_PCLK 3
`define RX_LEVEL_HOLD_PCLK 12
`define CLK_PER_PCLK 1
`endif

// ===== hdl/spi_irq_dma_ctrl.sv
// SPI interrupt, error detection and DMA request logic with link-side byte framing
`timescale 1ns/10ps
`include "spi_irq_cfg.svh"

module spi_irq_dma_ctrl #(
    parameter int RX_DEPTH = `RX_FIFO_DEPTH,
    parameter int TX_LAT = `TX_IRQ_LAT_PCLK * `CLK_PER_PCLK,
    parameter int RX_HOLD = `RX_LEVEL_HOLD_PCLK * `CLK_PER_PCLK
) (
    input wire logic clk_in, // Peripheral clock
    input wire logic rst_n_in, // Async reset
    input wire logic link_clk_in, // Serial clock
    input wire logic [15:0] ctrl_in, // Control word
    input wire logic ctrl_wr_in, // Control write pulse
    input wire logic [2:0] dma_ctrl_in, // DMA control word
    input wire logic bit_counter_reset_in, // Clear bit count on deselect
    input wire logic master_mode_in, // Master operation
    input wire logic status_rd_in, // Status read pulse
    input wire logic rx_read_in, // Receive data read pulse
    input wire logic tx_byte_load_in, // Byte moved to shifter
    input wire logic transfer_start_in, // Transfer start pulse
    input wire logic tx_fifo_empty_in, // Transmit FIFO empty
    input wire logic tx_fifo_full_in, // Transmit FIFO full
    input wire logic tx_bit_in, // Serial bit from shifter
    input wire logic chip_select_n_in, // Chip select pin
    input wire logic mosi_in, // Master out pin level
    output logic mosi_out, // Master out pin value
    output logic mosi_oe_n_out, // Master out enable
    input wire logic miso_in, // Master in pin level
    output logic miso_out, // Master in pin value
    output logic miso_oe_n_out, // Master in enable
    output logic [7:0] rx_data_out, // Oldest received byte
    output spi_irq_pkg::status_t status_out, // Status word
    output logic irq_out, // Interrupt line
    output spi_irq_pkg::dma_req_t dma_req_out // DMA requests
);

    localparam int CW = $clog2(RX_DEPTH + 1);
    localparam int PW = $clog2(RX_DEPTH);
    localparam int GW = $clog2(RX_HOLD + 1);
    localparam int NF = 5;

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    logic en;
    logic tx_sel;
    logic rx_flush;
    logic tx_flush;
    logic [1:0] mode;
    logic dma_on;
    logic dma_thr_block;

    assign en = ctrl_in[`CTRL_ENABLE_BIT];
    assign tx_sel = ctrl_in[`CTRL_IRQ_SRC_SEL_BIT];
    assign rx_flush = ctrl_in[`CTRL_RX_FLUSH_BIT];
    assign tx_flush = ctrl_in[`CTRL_TX_FLUSH_BIT];
    assign mode = ctrl_in[`CTRL_MODE_HI:`CTRL_MODE_LO];
    assign dma_on = dma_ctrl_in[`DMA_ENABLE_BIT];
    // Threshold interrupts are not produced while a DMA channel runs
    assign dma_thr_block = dma_on & (dma_ctrl_in[`DMA_TX_BIT] | dma_ctrl_in[`DMA_RX_BIT]);

    // ------------------------------------------------------------
    // Link domain: bit framing and receive capture
    // ------------------------------------------------------------
    logic link_clr_n;
    logic [2:0] bit_cnt_q;
    logic mid_byte_q;
    logic [6:0] shift_q;
    logic [7:0] rx_hold_q;
    logic rx_tgl_q;
    logic rx_bit;
    logic dout_q;

    // Deselect clears the bit count unless a mid-byte stall is wanted
    assign link_clr_n = rst_n_in & ~(chip_select_n_in & bit_counter_reset_in);
    assign rx_bit = master_mode_in ? miso_in : mosi_in;

    always_ff @(posedge link_clk_in or negedge link_clr_n) begin
        if (!link_clr_n) begin
            bit_cnt_q <= 3'h0;
            mid_byte_q <= 1'b0;
        end else if (!chip_select_n_in) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            mid_byte_q <= (bit_cnt_q != 3'h7);
        end
    end

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_q <= 7'h00;
            rx_hold_q <= 8'h00;
            rx_tgl_q <= 1'b0;
        end else if (!chip_select_n_in) begin
            shift_q <= {shift_q[5:0], rx_bit};
            if (bit_cnt_q == 3'h7) begin
                // Held for a whole byte time, so the core reads it after the toggle
                rx_hold_q <= {shift_q, rx_bit};
                rx_tgl_q <= ~rx_tgl_q;
            end
        end
    end

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dout_q <= 1'b1;
        end else begin
            dout_q <= tx_bit_in;
        end
    end

    // ------------------------------------------------------------
    // Data pads
    // ------------------------------------------------------------
    logic od;
    logic mosi_drv;
    logic miso_drv;

    assign od = ctrl_in[`CTRL_OPEN_DRAIN_BIT];
    assign mosi_drv = en & master_mode_in;
    assign miso_drv = en & ~master_mode_in & ~chip_select_n_in;

    // Open drain only pulls low and releases the pad for a one
    assign mosi_out = od ? 1'b0 : dout_q;
    assign mosi_oe_n_out = ~(mosi_drv & (~od | ~dout_q));
    assign miso_out = od ? 1'b0 : dout_q;
    assign miso_oe_n_out = ~(miso_drv & (~od | ~dout_q));

    // ------------------------------------------------------------
    // Crossings into the core clock
    // ------------------------------------------------------------
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic mid_s1_q;
    logic mid_s2_q;
    logic [1:0] mid_hist_q;
    logic rt_s1_q;
    logic rt_s2_q;
    logic rt_s3_q;
    logic cs_rise;
    logic cs_fall;
    logic rx_evt;
    logic cs_err_evt;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            mid_s1_q <= 1'b0;
            mid_s2_q <= 1'b0;
            mid_hist_q <= 2'h0;
            rt_s1_q <= 1'b0;
            rt_s2_q <= 1'b0;
            rt_s3_q <= 1'b0;
        end else begin
            cs_s1_q <= chip_select_n_in;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            mid_s1_q <= mid_byte_q;
            mid_s2_q <= mid_s1_q;
            mid_hist_q <= {mid_hist_q[0], mid_s2_q};
            rt_s1_q <= rx_tgl_q;
            rt_s2_q <= rt_s1_q;
            rt_s3_q <= rt_s2_q;
        end
    end

    assign cs_rise = cs_s2_q & ~cs_s3_q;
    assign cs_fall = ~cs_s2_q & cs_s3_q;
    assign rx_evt = rt_s2_q ^ rt_s3_q;
    // The bit count clears with deselect, so look at it from before the edge
    assign cs_err_evt = cs_rise & mid_hist_q[1];

    // ------------------------------------------------------------
    // Receive FIFO
    // ------------------------------------------------------------
    logic [7:0] mem_q [RX_DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic fifo_clr;
    logic do_wr;
    logic do_rd;
    logic ovf_evt;
    logic rx_thr_evt;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(RX_DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_inc

    assign fifo_clr = rx_flush | ~en;
    // With the flush bit high incoming bytes are not stored at all
    assign do_wr = rx_evt & ~fifo_clr & (cnt_q != CW'(RX_DEPTH));
    assign ovf_evt = rx_evt & ~fifo_clr & (cnt_q == CW'(RX_DEPTH));
    assign do_rd = rx_read_in & (cnt_q != '0) & ~fifo_clr;

    always_comb begin
        cnt_d = cnt_q;
        if (fifo_clr) begin
            cnt_d = '0;
        end else if (do_wr && !do_rd) begin
            cnt_d = cnt_q + CW'(1);
        end else if (do_rd && !do_wr) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            if (fifo_clr) begin
                wr_ptr_q <= '0;
                rd_ptr_q <= '0;
            end else begin
                if (do_wr) begin
                    wr_ptr_q <= ptr_inc(wr_ptr_q);
                end
                if (do_rd) begin
                    rd_ptr_q <= ptr_inc(rd_ptr_q);
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem_q[wr_ptr_q] <= rx_hold_q;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_data_out <= 8'h00;
        end else if (cnt_d == '0) begin
            rx_data_out <= 8'h00;
        end else if (do_wr && cnt_q == '0) begin
            rx_data_out <= rx_hold_q;
        end else begin
            rx_data_out <= mem_q[do_rd ? ptr_inc(rd_ptr_q) : rd_ptr_q];
        end
    end

    // Judged on the fill level after the write, not on bytes received
    assign rx_thr_evt = do_wr & ~tx_sel & ~dma_thr_block
        & (cnt_d > CW'(mode));

    // ------------------------------------------------------------
    // Fill level status with first byte hold-off
    // ------------------------------------------------------------
    logic [GW-1:0] guard_q;
    logic [2:0] level_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            guard_q <= '0;
        end else if (cs_fall) begin
            guard_q <= GW'(RX_HOLD);
        end else if (guard_q != '0) begin
            guard_q <= guard_q - GW'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_q <= 3'h0;
        end else if (fifo_clr || guard_q == '0) begin
            level_q <= 3'(cnt_d);
        end
    end

    // ------------------------------------------------------------
    // Transmit byte counter and start-up latency
    // ------------------------------------------------------------
    logic [1:0] tx_cnt_q;
    logic tx_hit;
    logic [TX_LAT-1:0] tx_pipe_q;
    logic [TX_LAT-1:0] ur_pipe_q;

    // Counts bytes moved into the shifter, whatever the FIFO holds
    assign tx_hit = tx_byte_load_in & ~ctrl_wr_in & (tx_cnt_q == mode);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_cnt_q <= 2'h0;
        end else if (ctrl_wr_in) begin
            tx_cnt_q <= 2'h0;
        end else if (tx_byte_load_in) begin
            tx_cnt_q <= tx_hit ? 2'h0 : tx_cnt_q + 2'h1;
        end
    end

    // Delay both events so they land inside the first byte, as in full duplex
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_pipe_q <= '0;
            ur_pipe_q <= '0;
        end else begin
            tx_pipe_q <= {tx_pipe_q[TX_LAT-2:0], tx_hit};
            ur_pipe_q <= {ur_pipe_q[TX_LAT-2:0],
                transfer_start_in & tx_fifo_empty_in};
        end
    end

    // ------------------------------------------------------------
    // Sticky source flags
    // ------------------------------------------------------------
    logic [NF-1:0] flag_set;
    logic [NF-1:0] flag_clr;
    logic [NF-1:0] flag_q;

    always_comb begin
        flag_set = '0;
        flag_clr = {NF{status_rd_in | ~en}};
        flag_set[spi_irq_pkg::FLAG_UNDERRUN] = en & ur_pipe_q[TX_LAT-1] & ~tx_flush;
        flag_set[spi_irq_pkg::FLAG_TX_THR] = en & tx_pipe_q[TX_LAT-1] & tx_sel
            & ~tx_flush & ~dma_thr_block;
        flag_set[spi_irq_pkg::FLAG_RX_THR] = en & rx_thr_evt & ~rx_flush;
        flag_set[spi_irq_pkg::FLAG_OVERFLOW] = en & ovf_evt;
        flag_set[spi_irq_pkg::FLAG_CS_ERR] = en & cs_err_evt;
        flag_clr[spi_irq_pkg::FLAG_UNDERRUN] = flag_clr[0] | tx_flush;
        flag_clr[spi_irq_pkg::FLAG_TX_THR] = flag_clr[1] | tx_flush;
        flag_clr[spi_irq_pkg::FLAG_RX_THR] = flag_clr[2] | rx_flush;
        flag_clr[spi_irq_pkg::FLAG_OVERFLOW] = flag_clr[3] | rx_flush;
    end

    // A set in the cycle of a clear still wins, so no event is lost
    for (genvar i = 0; i < NF; i++) begin : g_flag
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                flag_q[i] <= 1'b0;
            end else if (flag_set[i]) begin
                flag_q[i] <= 1'b1;
            end else if (flag_clr[i]) begin
                flag_q[i] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt line, status word and DMA requests
    // ------------------------------------------------------------
    assign irq_out = |flag_q;

    always_comb begin
        status_out = spi_irq_pkg::status_t'(`STATUS_RESET);
        status_out.irq = irq_out;
        status_out.tx_underrun = flag_q[spi_irq_pkg::FLAG_UNDERRUN];
        status_out.tx_threshold_irq = flag_q[spi_irq_pkg::FLAG_TX_THR];
        status_out.rx_threshold_irq = flag_q[spi_irq_pkg::FLAG_RX_THR];
        status_out.rx_overflow = flag_q[spi_irq_pkg::FLAG_OVERFLOW];
        status_out.rx_level = level_q;
        status_out.chip_select_error = flag_q[spi_irq_pkg::FLAG_CS_ERR];
    end

    // Requests keep the transmit FIFO topped up and drain the receive FIFO
    assign dma_req_out.tx = en & dma_on & dma_ctrl_in[`DMA_TX_BIT]
        & ~tx_fifo_full_in;
    assign dma_req_out.rx = en & dma_on & dma_ctrl_in[`DMA_RX_BIT]
        & (cnt_q != '0);

endmodule : spi_irq_dma_ctrl

// ===== hdl/spi_irq_pkg.sv
// Types shared by the SPI event block
package spi_irq_pkg;
    typedef struct packed {
        logic reserved_15;
        logic reserved_14;
        logic reserved_13;
        logic chip_select_error;
        logic reserved_11;
        logic [2:0] rx_level;
        logic rx_overflow;
        logic rx_threshold_irq;
        logic tx_threshold_irq;
        logic tx_underrun;
        logic [2:0] reserved_3_1;
        logic irq;
    } status_t;
    typedef struct packed {
        logic tx;
        logic rx;
    } dma_req_t;
    typedef enum logic [2:0] {
        FLAG_UNDERRUN = 3'h0,
        FLAG_TX_THR = 3'h1,
        FLAG_RX_THR = 3'h2,
        FLAG_OVERFLOW = 3'h3,
        FLAG_CS_ERR = 3'h4
    } flag_idx_t;
endpackage : spi_irq_pkg
